// ---- shared/sensor_pkg.sv ----
// Purpose: shared constants for the sensor readout end and its sequencer
// Assumes: one 200 MHz clock, strobes are one-cycle enables
// Notes: host register map lives here too
package sensor_pkg;
  // clock and converter timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int PIXEL_PERIOD_NS = 100;
  localparam int HALF_PIXEL_CYCLES = (PIXEL_PERIOD_NS * 1000) / (2 * CLK_PERIOD_PS);
  localparam int ADC_LAT_HALF = 13;  // 6.5 converter cycles in half cycles
  localparam int COL_STEPS_PER_PIXEL = 2;
  // array and bus geometry
  localparam int ROWS = 1024;
  localparam int COLS = 1024;
  localparam int IDX_W = 10;
  localparam int BUS_W = 10;
  localparam int ADC_W = 12;
  localparam int PARAM_W = 8;
  localparam int PARAM_COUNT = 4;
  localparam int PARAM_SEL_HI = 9;
  localparam int PARAM_SEL_LO = 8;
  // end-of-scan source field in parameter 0
  localparam int EOS_PARAM = 0;
  localparam logic [1:0] EOS_ROW_READ = 2'h0;
  localparam logic [1:0] EOS_ROW_RESET = 2'h1;
  localparam logic [1:0] EOS_COLUMN = 2'h2;
  localparam logic [PARAM_W-1:0] PARAM_RESET = 8'h00;
  // host register map
  localparam int AXI_ADDR_W = 8;
  localparam logic [AXI_ADDR_W-1:0] COMMAND_OFF = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] PROG_BUS_OFF = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] LINE_CTRL_OFF = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] STATUS_OFF = 8'h0C;
  localparam logic [AXI_ADDR_W-1:0] ADC_DATA_OFF = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // command bits, write one to pulse
  localparam int CMD_W = 11;
  localparam int CMD_ROW_START = 0;
  localparam int CMD_COL_START = 1;
  localparam int CMD_PARAM = 2;
  localparam int CMD_ROW_READ_SYNC = 3;
  localparam int CMD_ROW_RESET_SYNC = 4;
  localparam int CMD_COL_SYNC = 5;
  localparam int CMD_ROW_READ_ADV = 6;
  localparam int CMD_ROW_RESET_ADV = 7;
  localparam int CMD_COL_PIXEL = 8;
  localparam int CMD_RESET_SAMPLE = 9;
  localparam int CMD_SIGNAL_SAMPLE = 10;
  // line control bits
  localparam int LINE_W = 7;
  localparam int LC_CHOICE = 0;
  localparam int LC_LINE_RESET = 1;
  localparam int LC_LINE_SELECT = 2;
  localparam int LC_BLANKING = 3;
  localparam int LC_BUS_A = 4;
  localparam int LC_CLEAR_LOW = 5;
  localparam int LC_CONV_RUN = 6;
  localparam logic [LINE_W-1:0] LINE_CTRL_RESET = 7'h08;
  // status bits
  localparam int ST_SCAN_END = 0;
  localparam int ST_COL_BUSY = 1;
endpackage : sensor_pkg

// ---- shared/sensor_link_if.sv ----
// Purpose: pins between the sensor readout end and the sequencer
// Assumes: every signal is synchronous to aclk
// Notes: strobes are one-cycle pulses, converter_half marks half periods
`timescale 1ns/1ps
`default_nettype none
interface sensor_link_if (
  input wire logic aclk
);
  import sensor_pkg::*;
  logic [BUS_W-1:0] prog_bus;
  logic row_start_load;
  logic column_start_load;
  logic parameter_load;
  logic register_clear_low;
  logic row_read_sync;
  logic row_reset_sync;
  logic column_read_sync;
  logic row_read_advance;
  logic row_reset_advance;
  logic column_advance;
  logic row_pointer_choice;
  logic line_reset;
  logic line_select;
  logic blanking;
  logic column_bus_a;
  logic reset_level_sample;
  logic signal_level_sample;
  logic converter_half;
  logic [ADC_W-1:0] conversion_data;
  logic scan_end_flag;
  modport sensor (
    input prog_bus, row_start_load, column_start_load, parameter_load, register_clear_low,
    input row_read_sync, row_reset_sync, column_read_sync, row_read_advance,
    input row_reset_advance, column_advance, row_pointer_choice, line_reset, line_select,
    input blanking, column_bus_a, reset_level_sample, signal_level_sample, converter_half,
    output conversion_data, scan_end_flag
  );
  modport sequencer (
    output prog_bus, row_start_load, column_start_load, parameter_load, register_clear_low,
    output row_read_sync, row_reset_sync, column_read_sync, row_read_advance,
    output row_reset_advance, column_advance, row_pointer_choice, line_reset, line_select,
    output blanking, column_bus_a, reset_level_sample, signal_level_sample, converter_half,
    input conversion_data, scan_end_flag
  );
endinterface : sensor_link_if
`default_nettype wire

// ---- verilog/scan_pointer.sv ----
// Purpose: one-hot pointer shift register with start load and advance
// Assumes: load and advance are one-cycle enables
// Notes: load wins over advance; last position wraps to the first
`timescale 1ns/1ps
`default_nettype none
module scan_pointer #(
  parameter int unsigned LENGTH = sensor_pkg::ROWS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear_low,
  input wire logic load,
  input wire logic [sensor_pkg::IDX_W-1:0] start_index,
  input wire logic advance,
  output logic [sensor_pkg::IDX_W-1:0] index,
  output logic at_end
);
  import sensor_pkg::*;
  typedef struct packed {
    logic [LENGTH-1:0] one_hot;
    logic [IDX_W-1:0] index;
    logic at_end;
  } ptr_state_t;
  localparam ptr_state_t PTR_RESET = '{one_hot: {{(LENGTH-1){1'b0}}, 1'b1}, default: '0};
  ptr_state_t st_reg;
  ptr_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (load) begin
      st_next.one_hot = '0;
      st_next.one_hot[start_index] = 1'b1;
      st_next.index = start_index;
    end else if (advance) begin
      st_next.one_hot = {st_reg.one_hot[LENGTH-2:0], st_reg.one_hot[LENGTH-1]};
      st_next.index = st_reg.index + 10'h001;
    end
    st_next.at_end = st_next.one_hot[LENGTH-1];
  end

  always_ff @(posedge aclk or negedge clear_low) begin
    if (!clear_low) begin
      st_reg <= PTR_RESET;
    end else if (!aresetn) begin
      st_reg <= PTR_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign index = st_reg.index;
  assign at_end = st_reg.at_end;
endmodule : scan_pointer
`default_nettype wire

// ---- verilog/sensor_readout_end.sv ----
// Purpose: digital control of the line-addressed pixel array, sensor side
// Assumes: every strobe is a one-cycle pulse from the sequencer
// Notes: analog effects appear as registered drive and capture outputs
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - ten-bit shared address and data bus
// - row load strobe captures all ten bits
// - column load strobe captures all ten bits
// - parameter strobe stores low byte, upper selects
// - register clear acts without a clock
// - row read sync loads row start
// - row reset sync loads row start
// - column sync loads column start
// - row read advance steps one row
// - row reset advance steps one row
// - two column clocks per output pixel
// - end-of-scan source chosen by parameter
// - choice low read pointer, high reset
// - line reset acts on addressed row
// - line select drives addressed row out
// - blanking follows the software-set line control bit
// - reset sample strobe captures reset level
// - signal sample strobe captures signal level
// - converter data after 6.5 converter cycles
// - twelve-bit result, top bit most significant
// - row pointers stay one-hot
module sensor_readout_end (
  input wire logic aclk,
  input wire logic aresetn,
  sensor_link_if.sensor link,
  input wire logic [sensor_pkg::ADC_W-1:0] conversion_input,
  output logic [sensor_pkg::IDX_W-1:0] addressed_row,
  output logic row_reset_drive,
  output logic row_select_drive,
  output logic [sensor_pkg::IDX_W-1:0] column_index,
  output logic column_bus_a_drive,
  output logic reset_level_capture,
  output logic signal_level_capture,
  output logic readout_blanked,
  output logic [sensor_pkg::PARAM_COUNT*sensor_pkg::PARAM_W-1:0] parameter_values
);
  import sensor_pkg::*;

  typedef struct packed {
    logic [BUS_W-1:0] row_start;
    logic [BUS_W-1:0] column_start;
    logic [PARAM_COUNT-1:0][PARAM_W-1:0] params;
    logic col_phase;
    logic [ADC_LAT_HALF-1:0][ADC_W-1:0] adc_pipe;
    logic [ADC_W-1:0] adc_out;
    logic scan_end;
    logic [IDX_W-1:0] addressed_row;
    logic row_reset_drive;
    logic row_select_drive;
    logic column_bus_a_drive;
    logic reset_level_capture;
    logic signal_level_capture;
    logic readout_blanked;
  } dev_state_t;

  localparam dev_state_t DEV_RESET = '{params: {PARAM_COUNT{PARAM_RESET}}, default: '0};

  dev_state_t st_reg;
  dev_state_t st_next;
  logic [IDX_W-1:0] read_index;
  logic [IDX_W-1:0] reset_index;
  logic [IDX_W-1:0] col_index;
  logic read_end;
  logic reset_end;
  logic col_end;
  logic col_step;
  logic [1:0] eos_source;

  // column pointer moves on every second column clock
  assign col_step = link.column_advance & st_reg.col_phase;
  assign eos_source = st_reg.params[EOS_PARAM][1:0];

  scan_pointer #(
    .LENGTH(ROWS)
  ) row_read_pointer (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear_low(link.register_clear_low),
    .load(link.row_read_sync),
    .start_index(st_reg.row_start),
    .advance(link.row_read_advance),
    .index(read_index),
    .at_end(read_end)
  );

  scan_pointer #(
    .LENGTH(ROWS)
  ) row_reset_pointer (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear_low(link.register_clear_low),
    .load(link.row_reset_sync),
    .start_index(st_reg.row_start),
    .advance(link.row_reset_advance),
    .index(reset_index),
    .at_end(reset_end)
  );

  scan_pointer #(
    .LENGTH(COLS)
  ) column_read_pointer (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear_low(link.register_clear_low),
    .load(link.column_read_sync),
    .start_index(st_reg.column_start),
    .advance(col_step),
    .index(col_index),
    .at_end(col_end)
  );

  always_comb begin
    st_next = st_reg;
    // programming port, row and column starts take the whole bus as one word
    if (link.row_start_load) begin
      st_next.row_start = link.prog_bus;
    end
    if (link.column_start_load) begin
      st_next.column_start = link.prog_bus;
    end
    if (link.parameter_load) begin
      st_next.params[link.prog_bus[PARAM_SEL_HI:PARAM_SEL_LO]] = link.prog_bus[PARAM_W-1:0];
    end
    // phase of the two-clock pixel step
    if (link.column_read_sync) begin
      st_next.col_phase = 1'b0;
    end else if (link.column_advance) begin
      st_next.col_phase = ~st_reg.col_phase;
    end
    // array addressing from the chosen row pointer
    if (link.row_pointer_choice) begin
      st_next.addressed_row = reset_index;
    end else begin
      st_next.addressed_row = read_index;
    end
    st_next.row_reset_drive = link.line_reset;
    st_next.row_select_drive = link.line_select;
    st_next.column_bus_a_drive = link.column_bus_a;
    st_next.readout_blanked = link.blanking;
    st_next.reset_level_capture = link.reset_level_sample;
    st_next.signal_level_capture = link.signal_level_sample;
    // end-of-scan monitor
    case (eos_source)
      EOS_ROW_READ: begin
        st_next.scan_end = read_end;
      end
      EOS_ROW_RESET: begin
        st_next.scan_end = reset_end;
      end
      EOS_COLUMN: begin
        st_next.scan_end = col_end;
      end
      default: begin
        st_next.scan_end = 1'b0;
      end
    endcase
    // converter pipeline, one stage per half converter period
    if (link.converter_half) begin
      st_next.adc_pipe[0] = conversion_input;
      for (int i = 1; i < ADC_LAT_HALF; i++) begin
        st_next.adc_pipe[i] = st_reg.adc_pipe[i-1];
      end
      st_next.adc_out = st_reg.adc_pipe[ADC_LAT_HALF-1];
    end
  end

  // clear is asynchronous and active low, aresetn is synchronous
  always_ff @(posedge aclk or negedge link.register_clear_low) begin
    if (!link.register_clear_low) begin
      st_reg <= DEV_RESET;
    end else if (!aresetn) begin
      st_reg <= DEV_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // pointers hold a single set bit at all times
  assign link.conversion_data = st_reg.adc_out;
  assign link.scan_end_flag = st_reg.scan_end;
  assign addressed_row = st_reg.addressed_row;
  assign row_reset_drive = st_reg.row_reset_drive;
  assign row_select_drive = st_reg.row_select_drive;
  assign column_index = col_index;
  assign column_bus_a_drive = st_reg.column_bus_a_drive;
  assign reset_level_capture = st_reg.reset_level_capture;
  assign signal_level_capture = st_reg.signal_level_capture;
  assign readout_blanked = st_reg.readout_blanked;
  assign parameter_values = st_reg.params;
endmodule : sensor_readout_end
`default_nettype wire

// ---- verilog/sensor_sequencer_end.sv ----
// Purpose: sequencer end driving the sensor strobes from AXI4-Lite registers
// Assumes: software paces commands, one command write per strobe group
// Notes: a column pixel command issues two column clocks back to back
`timescale 1ns/1ps
`default_nettype none
module sensor_sequencer_end (
  input wire logic aclk,
  input wire logic aresetn,
  sensor_link_if.sequencer link,
  input wire logic [sensor_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sensor_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import sensor_pkg::*;

  typedef enum logic [4:0] {
    AX_IDLE = 5'b00001,
    AX_WTAKE = 5'b00010,
    AX_BRESP = 5'b00100,
    AX_RTAKE = 5'b01000,
    AX_RRESP = 5'b10000
  } axi_state_t;

  typedef struct packed {
    axi_state_t ax;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [BUS_W-1:0] prog_bus;
    logic [LINE_W-1:0] line_ctrl;
    logic [CMD_W-1:0] cmd;
    logic column_pulse;
    logic col_second;
    logic [7:0] half_count;
    logic converter_half;
    logic [ADC_W-1:0] adc_data;
  } seq_state_t;

  localparam seq_state_t SEQ_RESET = '{ax: AX_IDLE, line_ctrl: LINE_CTRL_RESET, default: '0};
  localparam logic [7:0] HALF_LAST = 8'(HALF_PIXEL_CYCLES - 1);

  seq_state_t st_reg;
  seq_state_t st_next;
  logic [31:0] wmask;
  logic [31:0] wbits;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{s_axi_wstrb[b]}};
    end
  end
  assign wbits = s_axi_wdata & wmask;

  always_comb begin
    st_next = st_reg;
    st_next.cmd = '0;
    st_next.col_second = 1'b0;
    st_next.converter_half = 1'b0;
    // second column clock follows the first
    st_next.column_pulse = st_reg.col_second;
    case (st_reg.ax)
      AX_IDLE: begin
        if (s_axi_awvalid && s_axi_wvalid) begin
          st_next.awready = 1'b1;
          st_next.wready = 1'b1;
          st_next.ax = AX_WTAKE;
        end else if (s_axi_arvalid) begin
          st_next.arready = 1'b1;
          st_next.ax = AX_RTAKE;
        end
      end
      AX_WTAKE: begin
        st_next.awready = 1'b0;
        st_next.wready = 1'b0;
        st_next.bvalid = 1'b1;
        st_next.bresp = RESP_OKAY;
        st_next.ax = AX_BRESP;
        case (s_axi_awaddr)
          COMMAND_OFF: begin
            st_next.cmd = wbits[CMD_W-1:0];
            st_next.cmd[CMD_COL_PIXEL] = 1'b0;
            st_next.column_pulse = wbits[CMD_COL_PIXEL];
            st_next.col_second = wbits[CMD_COL_PIXEL];
          end
          PROG_BUS_OFF: begin
            st_next.prog_bus = (st_reg.prog_bus & ~wmask[BUS_W-1:0]) | wbits[BUS_W-1:0];
          end
          LINE_CTRL_OFF: begin
            // blanking stays under software control
            st_next.line_ctrl = (st_reg.line_ctrl & ~wmask[LINE_W-1:0]) | wbits[LINE_W-1:0];
          end
          default: begin
            st_next.bresp = RESP_SLVERR;
          end
        endcase
      end
      AX_BRESP: begin
        if (s_axi_bready) begin
          st_next.bvalid = 1'b0;
          st_next.ax = AX_IDLE;
        end
      end
      AX_RTAKE: begin
        st_next.arready = 1'b0;
        st_next.rvalid = 1'b1;
        st_next.rresp = RESP_OKAY;
        st_next.rdata = '0;
        st_next.ax = AX_RRESP;
        case (s_axi_araddr)
          COMMAND_OFF: begin
            st_next.rdata = '0;
          end
          PROG_BUS_OFF: begin
            st_next.rdata[BUS_W-1:0] = st_reg.prog_bus;
          end
          LINE_CTRL_OFF: begin
            st_next.rdata[LINE_W-1:0] = st_reg.line_ctrl;
          end
          STATUS_OFF: begin
            st_next.rdata[ST_SCAN_END] = link.scan_end_flag;
            st_next.rdata[ST_COL_BUSY] = st_reg.col_second;
          end
          ADC_DATA_OFF: begin
            st_next.rdata[ADC_W-1:0] = st_reg.adc_data;
          end
          default: begin
            st_next.rresp = RESP_SLVERR;
          end
        endcase
      end
      AX_RRESP: begin
        if (s_axi_rready) begin
          st_next.rvalid = 1'b0;
          st_next.ax = AX_IDLE;
        end
      end
      default: begin
        st_next = SEQ_RESET;
      end
    endcase
    // converter clock at pixel rate as half-period pulses
    if (!st_reg.line_ctrl[LC_CONV_RUN]) begin
      st_next.half_count = '0;
    end else if (st_reg.half_count == HALF_LAST) begin
      st_next.half_count = '0;
      st_next.converter_half = 1'b1;
    end else begin
      st_next.half_count = st_reg.half_count + 8'h01;
    end
    if (st_reg.converter_half) begin
      st_next.adc_data = link.conversion_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= SEQ_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;
  assign link.prog_bus = st_reg.prog_bus;
  assign link.row_start_load = st_reg.cmd[CMD_ROW_START];
  assign link.column_start_load = st_reg.cmd[CMD_COL_START];
  assign link.parameter_load = st_reg.cmd[CMD_PARAM];
  assign link.row_read_sync = st_reg.cmd[CMD_ROW_READ_SYNC];
  assign link.row_reset_sync = st_reg.cmd[CMD_ROW_RESET_SYNC];
  assign link.column_read_sync = st_reg.cmd[CMD_COL_SYNC];
  assign link.row_read_advance = st_reg.cmd[CMD_ROW_READ_ADV];
  assign link.row_reset_advance = st_reg.cmd[CMD_ROW_RESET_ADV];
  assign link.column_advance = st_reg.column_pulse;
  assign link.reset_level_sample = st_reg.cmd[CMD_RESET_SAMPLE];
  assign link.signal_level_sample = st_reg.cmd[CMD_SIGNAL_SAMPLE];
  assign link.row_pointer_choice = st_reg.line_ctrl[LC_CHOICE];
  assign link.line_reset = st_reg.line_ctrl[LC_LINE_RESET];
  assign link.line_select = st_reg.line_ctrl[LC_LINE_SELECT];
  assign link.blanking = st_reg.line_ctrl[LC_BLANKING];
  assign link.column_bus_a = st_reg.line_ctrl[LC_BUS_A];
  assign link.register_clear_low = st_reg.line_ctrl[LC_CLEAR_LOW];
  assign link.converter_half = st_reg.converter_half;
endmodule : sensor_sequencer_end
`default_nettype wire

// ---- verification/pixel_array_readout_control_assertions.sv ----
// Purpose: link timing checks between sequencer and sensor ends
// Assumes: one clock, aresetn synchronous active low
// Notes: instantiated beside the link, no bind
`timescale 1ns/1ps
`default_nettype none
module sensor_link_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic parameter_load,
  input wire logic register_clear_low,
  input wire logic row_read_sync,
  input wire logic row_reset_sync,
  input wire logic column_read_sync,
  input wire logic row_read_advance,
  input wire logic row_reset_advance,
  input wire logic column_advance,
  input wire logic converter_half,
  input wire logic [sensor_pkg::ADC_W-1:0] conversion_data,
  input wire logic scan_end_flag
);
  import sensor_pkg::*;
  logic sync_any;
  logic adv_any;
  logic step;
  assign sync_any = row_read_sync | row_reset_sync | column_read_sync;
  assign adv_any = row_read_advance | row_reset_advance;
  assign step = sync_any | adv_any | column_advance | parameter_load;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_param_pulse: assert property (parameter_load |=> !parameter_load)
    else $error("parameter load wider than one cycle");
  a_clear_outputs: assert property (!register_clear_low |-> !scan_end_flag && conversion_data == '0)
    else $error("outputs not cleared while clear is low");
  a_column_pair: assert property ($rose(column_advance) |=> column_advance ##1 !column_advance)
    else $error("column clocks not a pair");
  a_sync_pulse: assert property (sync_any |=> !sync_any)
    else $error("sync strobe wider than one cycle");
  a_advance_pulse: assert property (adv_any |=> !adv_any)
    else $error("advance strobe wider than one cycle");
  a_end_cause: assert property ($rose(scan_end_flag) |-> $past(step) || $past(step, 2) || $past(step, 3))
    else $error("scan end rose without a pointer step");
  a_half_spacing: assert property (converter_half |=> !converter_half [*8])
    else $error("converter half pulses too close");
  a_data_on_half: assert property (register_clear_low && $past(register_clear_low) && $changed(conversion_data) |-> $past(converter_half))
    else $error("conversion data moved off a converter pulse");
endmodule : sensor_link_assertions
`default_nettype wire

// ---- verification/pixel_array_readout_control_tb.sv ----
// Purpose: bench joining sensor and sequencer ends over the link
// Assumes: AXI4-Lite handshakes sampled mid-cycle, driven after rising edges
// Notes: integer model of start registers, pointers and parameters
`timescale 1ns/1ps
`default_nettype none
module pixel_array_readout_control_tb;
  import sensor_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rst_drv, sel_drv, bus_a, cap_r, cap_s, blanked;
  logic [1:0] bresp, rresp, r;
  logic [31:0] wdata = 32'h0, rdata, params, d;
  logic [11:0] conv_in = 12'h000;
  logic [9:0] arow, acol, pbus;
  logic [15:0] lf = 16'h005A;
  logic [7:0] pm [4];
  logic [6:0] lc;
  int bad_count = 0, comparisons = 0, n_r = 0, n_s = 0, row_start, col_start, rd_p, rs_p, col_p;
  always #2.5 aclk = ~aclk;
  int cm [ADC_LAT_HALF+1];
  always @(posedge aclk) begin
    if (aresetn !== 1'b1 || link_bus.register_clear_low !== 1'b1) begin
      foreach (cm[i]) cm[i] <= 0;
    end else if (link_bus.converter_half === 1'b1) begin
      chk("conv", 32'(link_bus.conversion_data), cm[ADC_LAT_HALF]);
      foreach (cm[i]) cm[i] <= i ? cm[i-1] : int'(conv_in);
    end
  end
  always @(posedge aclk) begin
    n_r <= n_r + int'(cap_r === 1'b1);
    n_s <= n_s + int'(cap_s === 1'b1);
  end
  sensor_link_if link_bus (.aclk(aclk));
  sensor_readout_end u_sensor_readout_end (.aclk(aclk), .aresetn(aresetn), .link(link_bus),
    .conversion_input(conv_in), .addressed_row(arow), .row_reset_drive(rst_drv),
    .row_select_drive(sel_drv), .column_index(acol), .column_bus_a_drive(bus_a),
    .reset_level_capture(cap_r), .signal_level_capture(cap_s), .readout_blanked(blanked),
    .parameter_values(params));
  sensor_sequencer_end u_sensor_sequencer_end (.aclk(aclk), .aresetn(aresetn), .link(link_bus),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  sensor_link_assertions u_sensor_link_assertions (.aclk(aclk), .aresetn(aresetn),
    .parameter_load(link_bus.parameter_load), .register_clear_low(link_bus.register_clear_low),
    .row_read_sync(link_bus.row_read_sync), .row_reset_sync(link_bus.row_reset_sync),
    .column_read_sync(link_bus.column_read_sync), .column_advance(link_bus.column_advance),
    .row_read_advance(link_bus.row_read_advance), .converter_half(link_bus.converter_half),
    .row_reset_advance(link_bus.row_reset_advance), .scan_end_flag(link_bus.scan_end_flag),
    .conversion_data(link_bus.conversion_data));
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", n, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ga, gw, gb;
    gb = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!gb) begin
      @(negedge aclk);
      ga = awready;
      gw = wready;
      gb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ga) awvalid <= 1'b0;
      if (gw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ga, gr;
    gr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!gr) begin
      @(negedge aclk);
      ga = arready;
      gr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ga) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  task automatic wipe();
    row_start = 0;
    col_start = 0;
    rd_p = 0;
    rs_p = 0;
    col_p = 0;
    foreach (pm[i]) pm[i] = 8'h00;
  endtask : wipe
  task automatic cmp();
    int src, e;
    src = int'(pm[0][1:0]);
    e = src == 0 ? rd_p == 1023 : src == 1 ? rs_p == 1023 : src == 2 ? col_p == 1023 : 0;
    rd(STATUS_OFF);
    chk("scan end", d & 32'h1, 32'(e));
    chk("row", 32'(arow), lc[0] ? rs_p : rd_p);
    chk("column", 32'(acol), col_p);
    chk("params", params, {pm[3], pm[2], pm[1], pm[0]});
    chk("drives", 32'({rst_drv, sel_drv, blanked, bus_a}), 32'({lc[1], lc[2], lc[3], lc[4]} & {4{lc[5]}}));
  endtask : cmp
  task automatic go(input int b);
    wr(COMMAND_OFF, 32'h1 << b);
    repeat (4) @(posedge aclk);
    case (b)
      0: row_start = int'(pbus);
      1: col_start = int'(pbus);
      2: pm[pbus[9:8]] = pbus[7:0];
      3: rd_p = row_start;
      4: rs_p = row_start;
      5: col_p = col_start;
      6: rd_p = (rd_p + 1) % ROWS;
      7: rs_p = (rs_p + 1) % ROWS;
      8: col_p = (col_p + 1) % COLS;
      default: ;
    endcase
    cmp();
  endtask : go
  task automatic load(input int b, input logic [9:0] v);
    pbus = v;
    wr(PROG_BUS_OFF, 32'(v));
    go(b);
  endtask : load
  task automatic ctl(input logic [6:0] v);
    lc = v;
    wr(LINE_CTRL_OFF, 32'(v));
    repeat (3) @(posedge aclk);
    if (!v[LC_CLEAR_LOW]) wipe();
    cmp();
  endtask : ctl
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (40000) @(posedge aclk);
    bad_count++;
    complete_run();
  end
  initial begin
    wipe();
    lc = LINE_CTRL_RESET;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(LINE_CTRL_OFF);
    chk("line ctrl reset", d, 32'(LINE_CTRL_RESET));
    rd(8'h20);
    chk("unmapped read", 32'(r), 32'(RESP_SLVERR));
    wr(STATUS_OFF, 32'h1);
    chk("read only write", 32'(r), 32'(RESP_SLVERR));
    ctl(7'h68);
    for (int i = 0; i < 12; i++) begin
      lf = nx(lf);
      conv_in <= lf[11:0];
      load(2, {2'(i), lf[7:0]});
      load(0, lf[15:6]);
      go(3);
      go(4);
      go(6);
      go(7);
      ctl({2'b11, lf[3], 1'b1, lf[2], lf[1], lf[0]});
      load(1, lf[9:0]);
      go(5);
      go(8);
    end
    load(2, 10'h000);
    load(0, 10'h3FF);
    go(3);
    go(6);
    load(2, 10'h001);
    go(4);
    go(7);
    load(2, 10'h002);
    load(1, 10'h3FE);
    go(5);
    go(8);
    go(8);
    go(9);
    go(10);
    chk("reset samples", n_r, 1);
    chk("signal samples", n_s, 1);
    conv_in <= ~lf[11:0];
    repeat (300) @(posedge aclk);
    rd(ADC_DATA_OFF);
    chk("converter", d, 32'(conv_in));
    ctl(7'h48);
    complete_run();
  end
endmodule : pixel_array_readout_control_tb
`default_nettype wire
